// [dv/match_based_pwm_timer_test.sv]
// Purpose: self-checking bench of the match pwm timer
// Assumes: AXI4-Lite master tasks, load model on the outputs
// Notes:   prescale limit 0 in the pwm cases, period of ten counts
`timescale 1ns/1ps
`include "mpt_params.svh"
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin num_errors++; \
$display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module match_based_pwm_timer_test;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0, rdata, rv, seed = 32'h26FDD286;
   logic [3:0]  wstrb = 4'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0, awready, wready;
   logic        bvalid, arready, rvalid, sync_out, irq, win = 1'b0;
   logic [1:0]  bresp, rresp, cap_in = 2'h0;
   logic        sync_in = 1'b0;
   logic [6:1]  pwm_out;
   logic [15:0] hi [1:6], rs [1:6];
   logic [31:0] mr [0:6];
   int          num_errors = 0, comparisons = 0;
   always #5 aclk = ~aclk;
   mpt_top u_mpt_top (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .cap_in(cap_in), .sync_in(sync_in),
      .pwm_out(pwm_out), .sync_out(sync_out), .irq(irq));
   mpt_load u_mpt_load (.aclk(aclk), .win(win), .pwm(pwm_out), .hi(hi),
      .rs(rs));
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      s = s ^ (s << 5);
      return s;
   endfunction
   // high cycles of output k per period, pwm mode, prescale limit 0
   function automatic logic [15:0] exp_hi(input int k, input bit dbl);
      logic [31:0] p, r, f;
      p = mr[0] + 1;
      r = mr[k-1];
      f = mr[k];
      if (dbl) return 16'((r < f) ? f - r : p - (r - f));
      return 16'((f == 0) ? 0 : f + 1);
   endfunction
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] e = `MPT_OKAY);
      int n;
      n = 0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (n < 200) begin
         @(posedge aclk);
         n++;
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            `CHK(bresp, e)
            bready <= 1'b0;
            n = 300;
         end
      end
      if (n == 200) `CHK(1'b0, 1'b1)
   endtask
   task automatic rd(input logic [7:0] a, input logic [1:0] e = `MPT_OKAY);
      int n;
      n = 0;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (n < 200) begin
         @(posedge aclk);
         n++;
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            `CHK(rresp, e)
            rv = rdata;
            rready <= 1'b0;
            n = 300;
         end
      end
      if (n == 200) `CHK(1'b0, 1'b1)
   endtask
   task automatic meas(input int w);
      @(posedge aclk);
      win <= 1'b1;
      repeat (w + 1) @(posedge aclk);
      win <= 1'b0;
      @(posedge aclk);
   endtask
   task automatic pulse(input int c, input int n);
      repeat (n) begin
         cap_in[c] <= 1'b1;
         cap_in[1-c] <= ~cap_in[1-c];
         repeat (4) @(posedge aclk);
         cap_in[c] <= 1'b0;
         repeat (4) @(posedge aclk);
      end
      cap_in[1-c] <= 1'b0;
   endtask
   task automatic chk_pwm;
      meas(100);
      for (int k = 1; k <= 6; k++) begin
         `CHK(hi[k], 16'(10) * exp_hi(k, k == 4 || k == 6))
         `CHK(rs[k], (k == 2) ? 16'h0 : 16'hA)
      end
   endtask
   initial begin
      repeat (50000) @(posedge aclk);
      num_errors++;
      give_verdict;
   end
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`MPT_A_TC);
      `CHK(rv, 32'h0)
      rd(8'h30, `MPT_SLVERR);
      `CHK(rv, 32'h0)
      wr(8'h02, 32'h1, `MPT_SLVERR);
      // stop on match with flag and masked interrupt
      wr(`MPT_A_CTRL, 32'h2);
      wr(`MPT_A_PR, 32'h2);
      wr(`MPT_A_MR0 + 8'h04, 32'h5);
      wr(`MPT_A_MCR, 32'h28);
      wr(`MPT_A_MASK, 32'h2);
      wr(`MPT_A_CTRL, 32'h1);
      repeat (60) @(posedge aclk);
      rd(`MPT_A_CTRL);
      `CHK(rv, 32'h0)
      rd(`MPT_A_TC);
      `CHK(rv, 32'h5)
      rd(`MPT_A_STAT);
      `CHK(rv, 32'h2)
      `CHK(irq, 1'b1)
      wr(`MPT_A_MASK, 32'h0);
      repeat (3) @(posedge aclk);
      `CHK(irq, 1'b0)
      wr(`MPT_A_MASK, 32'h2);
      wr(`MPT_A_STAT, 32'h2);
      repeat (3) @(posedge aclk);
      `CHK(irq, 1'b0)
      rd(`MPT_A_STAT);
      `CHK(rv, 32'h0)
      // counter mode on each capture input
      wr(`MPT_A_PR, 32'h0);
      wr(`MPT_A_MCR, 32'h0);
      wr(`MPT_A_CTRL, 32'h2);
      wr(`MPT_A_CTRL, 32'h9);
      pulse(0, 5);
      rd(`MPT_A_TC);
      `CHK(rv, 32'h5)
      wr(`MPT_A_CTRL, 32'h19);
      pulse(1, 3);
      rd(`MPT_A_TC);
      `CHK(rv, 32'h8)
      // plain timer with reset on match, outputs stay low
      wr(`MPT_A_CTRL, 32'h2);
      wr(`MPT_A_PCR, 32'h7E50);
      wr(`MPT_A_MCR, 32'h10);
      wr(`MPT_A_CTRL, 32'h1);
      meas(50);
      for (int k = 1; k <= 6; k++) `CHK(hi[k], 16'h0)
      rd(`MPT_A_TC);
      `CHK(rv <= 32'h5, 1'b1)
      // pwm: three single, one constant low, two double edge outputs
      mr = '{32'h9, 32'h4, 32'h0, 32'h2, 32'h7, 32'h8, 32'h1};
      wr(`MPT_A_CTRL, 32'h2);
      wr(`MPT_A_MCR, 32'h0);
      for (int i = 0; i < 7; i++) wr(8'(`MPT_A_MR0 + 4 * i), mr[i]);
      wr(`MPT_A_CTRL, 32'h5);
      repeat (40) @(posedge aclk);
      chk_pwm;
      for (int j = 0; j < 3; j++) begin
         seed = xs(seed);
         rv = {29'h0, seed[2:0]} + 32'h1;
         wr(`MPT_A_MR0 + 8'h04, rv);
         chk_pwm;
         rd(`MPT_A_MR0 + 8'h04);
         `CHK(rv, {29'h0, seed[2:0]} + 32'h1)
         mr[1] = rv;
         wr(`MPT_A_LOAD, 32'h2);
         repeat (30) @(posedge aclk);
         rd(`MPT_A_LOAD);
         `CHK(rv, 32'h0)
         chk_pwm;
      end
      // lockstep follower
      `CHK(sync_out, 1'b1)
      wr(`MPT_A_CTRL, 32'h2);
      @(posedge aclk);
      `CHK(sync_out, 1'b0)
      wr(`MPT_A_CTRL, 32'h20);
      repeat (20) @(posedge aclk);
      rd(`MPT_A_TC);
      `CHK(rv, 32'h0)
      sync_in <= 1'b1;
      repeat (30) @(posedge aclk);
      sync_in <= 1'b0;
      rd(`MPT_A_TC);
      `CHK(rv != 32'h0, 1'b1)
      wdata <= rv;
      rd(`MPT_A_TC);
      `CHK(rv, wdata)
      give_verdict;
   end
endmodule

// [dv/mpt_load.sv]
// Purpose: load model on the modulated outputs, counts high time and rises
// Assumes: outputs sampled on aclk, window opened and closed by the bench
// Notes:   counters clear on the first cycle of each window
`timescale 1ns/1ps
module mpt_load (
   input  wire logic       aclk,
   input  wire logic       win,
   input  wire logic [6:1] pwm,
   output logic [15:0]     hi [1:6],
   output logic [15:0]     rs [1:6]
);
   logic [6:1] prv;
   logic       wp;
   always @(posedge aclk) begin
      wp <= win;
      prv <= pwm;
      for (int k = 1; k <= 6; k++) begin
         if (win && !wp) begin
            hi[k] <= 16'h0000;
            rs[k] <= 16'h0000;
         end else if (win) begin
            hi[k] <= hi[k] + 16'(pwm[k]);
            rs[k] <= rs[k] + 16'(pwm[k] & !prv[k]);
         end
      end
   end
endmodule

// [hw/mpt_axil.sv]
// Purpose: AXI4-Lite slave in front of the timer registers
// Assumes: one write and one read outstanding at most
// Notes:   unmapped addresses answer SLVERR
`timescale 1ns/1ps
`include "mpt_params.svh"
module mpt_axil (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [7:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   mpt_reg_if.bus           rif
);
   import mpt_pkg::*;
   mpt_axi_s s, n;

   always_comb begin
      n    = s;
      n.wr = 1'b0;
      if (awvalid && s.awready) begin
         n.aw_ok = 1'b1;
         n.waddr = awaddr;
      end
      if (wvalid && s.wready) begin
         n.w_ok  = 1'b1;
         n.wdata = wdata;
         n.wstrb = wstrb;
      end
      if (s.aw_ok && s.w_ok && !s.bvalid) begin
         n.wr     = rif.whit;
         n.aw_ok  = 1'b0;
         n.w_ok   = 1'b0;
         n.bvalid = 1'b1;
         n.bresp  = rif.whit ? `MPT_OKAY : `MPT_SLVERR;
      end
      if (s.bvalid && bready) begin
         n.bvalid = 1'b0;
      end
      if (arvalid && s.arready) begin
         n.raddr = araddr;
         n.rpend = 1'b1;
      end
      if (s.rpend) begin
         n.rpend  = 1'b0;
         n.rvalid = 1'b1;
         n.rdata  = rif.rdata;
         n.rresp  = rif.rhit ? `MPT_OKAY : `MPT_SLVERR;
      end
      if (s.rvalid && rready) begin
         n.rvalid = 1'b0;
      end
      n.awready = !n.aw_ok && !n.bvalid;
      n.wready  = !n.w_ok && !n.bvalid;
      n.arready = !n.rpend && !n.rvalid;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign awready   = s.awready;
   assign wready    = s.wready;
   assign bvalid    = s.bvalid;
   assign bresp     = s.bresp;
   assign arready   = s.arready;
   assign rvalid    = s.rvalid;
   assign rdata     = s.rdata;
   assign rresp     = s.rresp;
   assign rif.wr    = s.wr;
   assign rif.waddr = s.waddr;
   assign rif.raddr = s.raddr;
   assign rif.wdata = s.wdata;
   assign rif.wstrb = s.wstrb;
endmodule

// [hw/mpt_cap.sv]
// Purpose: capture input synchroniser and rising edge pulses
// Assumes: capture inputs are asynchronous pins
// Notes:   rise is a registered one-cycle pulse
`timescale 1ns/1ps
module mpt_cap (
   input  wire logic       aclk,
   input  wire logic       aresetn,
   input  wire logic [1:0] cap_in,
   output logic [1:0]      rise
);
   import mpt_pkg::*;
   mpt_cap_s s, n;

   always_comb begin
      n      = s;
      n.s1   = cap_in;
      n.s2   = s.s1;
      n.last = s.s2;
      n.rise = s.s2 & ~s.last;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign rise = s.rise;
endmodule

// [hw/mpt_params.svh]
// Purpose: register map and field positions of the timer
// Assumes: one aligned 32-bit word per register, byte addresses
// Notes:   definitions only
`ifndef MPT_PARAMS_SVH
`define MPT_PARAMS_SVH
`define MPT_A_CTRL  8'h00
`define MPT_A_TC    8'h04
`define MPT_A_PR    8'h08
`define MPT_A_PC    8'h0C
`define MPT_A_MCR   8'h10
`define MPT_A_STAT  8'h14
`define MPT_A_MASK  8'h18
`define MPT_A_LOAD  8'h1C
`define MPT_A_PCR   8'h20
`define MPT_A_MR0   8'h40
`define MPT_A_MRTOP 8'h58
`define MPT_C_EN    0
`define MPT_C_CRST  1
`define MPT_C_PWM   2
`define MPT_C_SRC   3
`define MPT_C_CSEL  4
`define MPT_C_SLV   5
`define MPT_M_INT   0
`define MPT_M_RST   1
`define MPT_M_STOP  2
`define MPT_M_W     3
`define MPT_P_OE    8
`define MPT_NM      7
`define MPT_OKAY    2'h0
`define MPT_SLVERR  2'h2
`endif

// [hw/mpt_pkg.sv]
// Purpose: state types of the match pwm timer
// Assumes: nothing
// Notes:   one packed struct per module
package mpt_pkg;
   typedef logic [31:0] mpt_word_t;
   typedef struct packed {
      logic       aw_ok, w_ok, awready, wready, arready;
      logic       bvalid, rvalid, rpend, wr;
      logic [7:0] waddr, raddr;
      mpt_word_t  wdata, rdata;
      logic [3:0] wstrb;
      logic [1:0] bresp, rresp;
   } mpt_axi_s;
   typedef struct packed {
      logic [1:0] s1, s2, last, rise;
   } mpt_cap_s;
   typedef struct packed {
      logic [5:0]      ctrl;
      mpt_word_t       tc, pr, pc;
      logic [20:0]     mcr;
      logic [6:0]      flag, mask, ld, dbl, oe;
      mpt_word_t [6:0] mr, sh;
      logic [6:1]      out;
      logic            irq, sync;
   } mpt_core_s;
endpackage

// [hw/mpt_reg_if.sv]
// Purpose: register access between bus slave and timer core
// Assumes: one clock
// Notes:   wr is a one-cycle pulse
`timescale 1ns/1ps
interface mpt_reg_if;
   logic        wr;
   logic [7:0]  waddr, raddr;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic        whit, rhit;
   modport bus  (output wr, waddr, raddr, wdata, wstrb,
                 input rdata, whit, rhit);
   modport regs (input wr, waddr, raddr, wdata, wstrb,
                 output rdata, whit, rhit);
endinterface

// [hw/mpt_top.sv]
// Purpose: match based pwm timer with seven match registers
// Assumes: AXI4-Lite register access, one clock, lockstep partner on
//          the same clock
// Notes:   a match acts when the prescaler rolls over at that count
//
// Summary of operation
// - 32-bit timer behind a 32-bit prescaler
// - count clock or a capture input edge
// - seven match registers feed six outputs
// - match may continue, stop or reset timer
// - in pwm mode match zero resets count, starts cycle
// - single-edge rises at cycle start, own fall
// - constant-low single-edge output never rises
// - double-edge uses two matches, either polarity
// - one match per single, two per double
// - all outputs share one repetition rate
// - released match values apply at cycle start
// - without pwm mode, plain timer, outputs low
// - primary enable drives secondary in lockstep
`timescale 1ns/1ps
`include "mpt_params.svh"
module mpt_top (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic [1:0]  cap_in,
   input  wire logic        sync_in,
   output logic [6:1]       pwm_out,
   output logic             sync_out,
   output logic             irq
);
   import mpt_pkg::*;

   mpt_core_s  s, n;
   mpt_reg_if  rif ();
   logic [1:0] cap_rise;
   logic       run, tick, adv, pwm, do_rst, do_stop;
   logic [6:0] m, rst_hit, stp_hit, int_hit;
   logic [6:1] out_nx;
   mpt_word_t  nv;

   mpt_axil u_axil (
      .aclk    (aclk),
      .aresetn (aresetn),
      .awaddr  (s_axi_awaddr),
      .awvalid (s_axi_awvalid),
      .awready (s_axi_awready),
      .wdata   (s_axi_wdata),
      .wstrb   (s_axi_wstrb),
      .wvalid  (s_axi_wvalid),
      .wready  (s_axi_wready),
      .bresp   (s_axi_bresp),
      .bvalid  (s_axi_bvalid),
      .bready  (s_axi_bready),
      .araddr  (s_axi_araddr),
      .arvalid (s_axi_arvalid),
      .arready (s_axi_arready),
      .rdata   (s_axi_rdata),
      .rresp   (s_axi_rresp),
      .rvalid  (s_axi_rvalid),
      .rready  (s_axi_rready),
      .rif     (rif.bus)
   );

   mpt_cap u_cap (
      .aclk    (aclk),
      .aresetn (aresetn),
      .cap_in  (cap_in),
      .rise    (cap_rise)
   );

   function automatic logic mr_hit(input logic [7:0] a);
      return a[1:0] == 2'h0 && a >= `MPT_A_MR0 && a <= `MPT_A_MRTOP;
   endfunction

   function automatic logic reg_hit(input logic [7:0] a);
      return (a inside {`MPT_A_CTRL, `MPT_A_TC, `MPT_A_PR, `MPT_A_PC,
                        `MPT_A_MCR, `MPT_A_STAT, `MPT_A_MASK,
                        `MPT_A_LOAD, `MPT_A_PCR}) || mr_hit(a);
   endfunction

   // match words read back the last written (shadow) value
   function automatic mpt_word_t rword(input logic [7:0] a);
      mpt_word_t r;
      r = '0;
      case (a)
         `MPT_A_CTRL: r[5:0] = s.ctrl;
         `MPT_A_TC:   r = s.tc;
         `MPT_A_PR:   r = s.pr;
         `MPT_A_PC:   r = s.pc;
         `MPT_A_MCR:  r[20:0] = s.mcr;
         `MPT_A_STAT: r[6:0] = s.flag;
         `MPT_A_MASK: r[6:0] = s.mask;
         `MPT_A_LOAD: r[6:0] = s.ld;
         `MPT_A_PCR: begin
            r[6:0] = s.dbl;
            r[`MPT_P_OE +: 7] = s.oe;
         end
         default: begin
            if (mr_hit(a)) begin
               r = s.sh[a[4:2]];
            end
         end
      endcase
      return r;
   endfunction

   function automatic mpt_word_t wmerge(input mpt_word_t o,
                                        input mpt_word_t d,
                                        input logic [3:0] b);
      mpt_word_t r;
      r = o;
      for (int k = 0; k < 4; k++) begin
         if (b[k]) begin
            r[8*k +: 8] = d[8*k +: 8];
         end
      end
      return r;
   endfunction

   // procedural so state changes refresh the read word
   always_comb begin
      rif.rdata = rword(rif.raddr);
   end
   assign rif.rhit  = reg_hit(rif.raddr);
   assign rif.whit  = reg_hit(rif.waddr);

   // secondary unit follows the primary enable
   assign run  = (s.ctrl[`MPT_C_SLV] ? sync_in : s.ctrl[`MPT_C_EN]) &&
                 !s.ctrl[`MPT_C_CRST];
   assign tick = s.ctrl[`MPT_C_SRC] ? cap_rise[s.ctrl[`MPT_C_CSEL]]
                                    : 1'b1;
   assign adv  = run && tick && (s.pc == s.pr);
   assign pwm  = s.ctrl[`MPT_C_PWM];

   genvar i;
   generate
      for (i = 0; i < `MPT_NM; i++) begin : g_match
         assign m[i]       = adv && (s.tc == s.mr[i]);
         assign rst_hit[i] = m[i] && s.mcr[`MPT_M_W*i + `MPT_M_RST];
         assign stp_hit[i] = m[i] && s.mcr[`MPT_M_W*i + `MPT_M_STOP];
         assign int_hit[i] = m[i] && s.mcr[`MPT_M_W*i + `MPT_M_INT];
      end
   endgenerate

   // in pwm mode match zero always closes the cycle
   assign do_rst  = (|rst_hit) || (pwm && m[0]);
   assign do_stop = |stp_hit;

   generate
      for (i = 1; i < `MPT_NM; i++) begin : g_out
         logic rise_c;
         // outputs 2..6 may take the previous match as rising edge
         assign rise_c = (i >= 2 && s.dbl[i]) ? m[i-1]
                       : m[0] && s.mr[i] != 32'h0;
         assign out_nx[i] = !(pwm && s.oe[i]) ? 1'b0
                          : m[i]              ? 1'b0
                          : rise_c            ? 1'b1
                          : s.out[i];
      end
   endgenerate

   always_comb begin
      n  = s;
      nv = wmerge(rword(rif.waddr), rif.wdata, rif.wstrb);
      if (s.ctrl[`MPT_C_CRST]) begin
         n.tc = 32'h0;
         n.pc = 32'h0;
      end else if (run && tick) begin
         if (adv) begin
            n.pc = 32'h0;
            if (do_rst) begin
               n.tc = 32'h0;
            end else if (!do_stop) begin
               n.tc = 32'(s.tc + 32'h1);
            end
            if (do_stop) begin
               n.ctrl[`MPT_C_EN] = 1'b0;
            end
         end else begin
            n.pc = 32'(s.pc + 32'h1);
         end
      end
      // released values take effect only at the cycle boundary
      if (pwm && m[0]) begin
         for (int k = 0; k < `MPT_NM; k++) begin
            if (s.ld[k]) begin
               n.mr[k] = s.sh[k];
               n.ld[k] = 1'b0;
            end
         end
      end
      if (rif.wr) begin
         case (rif.waddr)
            `MPT_A_CTRL: n.ctrl = nv[5:0];
            `MPT_A_TC:   n.tc = nv;
            `MPT_A_PR:   n.pr = nv;
            `MPT_A_PC:   n.pc = nv;
            `MPT_A_MCR:  n.mcr = nv[20:0];
            `MPT_A_STAT: n.flag = s.flag &
                                  ~(rif.wdata[6:0] & {7{rif.wstrb[0]}});
            `MPT_A_MASK: n.mask = nv[6:0];
            `MPT_A_LOAD: n.ld = n.ld |
                                (rif.wdata[6:0] & {7{rif.wstrb[0]}});
            `MPT_A_PCR: begin
               n.dbl = nv[6:0];
               n.oe  = nv[`MPT_P_OE +: 7];
            end
            default: begin
               if (mr_hit(rif.waddr)) begin
                  n.sh[rif.waddr[4:2]] = nv;
                  // plain timer mode writes straight through
                  if (!pwm) begin
                     n.mr[rif.waddr[4:2]] = nv;
                  end
               end
            end
         endcase
      end
      // set wins over a same-cycle clear
      n.flag = n.flag | int_hit;
      n.out  = out_nx;
      n.irq  = |(s.flag & s.mask);
      n.sync = n.ctrl[`MPT_C_EN] && !n.ctrl[`MPT_C_CRST];
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign pwm_out  = s.out;
   assign sync_out = s.sync;
   assign irq      = s.irq;

   a_presc_wrap:
   assert property (@(posedge aclk) disable iff (!aresetn)
      adv && !rif.wr |=> s.pc == 32'h0)
      else $error("prescaler did not restart at its limit");

   a_presc_hold:
   assert property (@(posedge aclk) disable iff (!aresetn)
      run && tick && !adv && !rif.wr
      |=> s.tc == $past(s.tc) && s.pc == $past(s.pc) + 32'h1)
      else $error("timer moved before prescaler limit");

   a_src_gate:
   assert property (@(posedge aclk) disable iff (!aresetn)
      s.ctrl[`MPT_C_SRC] && !tick && !rif.wr && !s.ctrl[`MPT_C_CRST]
      |=> $stable(s.pc) && $stable(s.tc))
      else $error("counter mode advanced without capture edge");

   a_stop_match:
   assert property (@(posedge aclk) disable iff (!aresetn)
      m[1] && s.mcr[`MPT_M_W + `MPT_M_STOP] && !do_rst && !rif.wr
      |=> !s.ctrl[`MPT_C_EN] && s.tc == $past(s.tc))
      else $error("stop on match did not halt the timer");

   a_cycle_reset:
   assert property (@(posedge aclk) disable iff (!aresetn)
      pwm && m[0] && !rif.wr |=> s.tc == 32'h0)
      else $error("cycle match did not restart the count");

   a_single_rise:
   assert property (@(posedge aclk) disable iff (!aresetn)
      pwm && s.oe[1] && m[0] && !m[1] && s.mr[1] != 32'h0
      |=> pwm_out[1])
      else $error("single edge output did not rise at cycle start");

   a_const_low:
   assert property (@(posedge aclk) disable iff (!aresetn)
      s.mr[2] == 32'h0 && !s.dbl[2] && !pwm_out[2] |=> !pwm_out[2])
      else $error("constant low output was driven high");

   a_dbl_rise:
   assert property (@(posedge aclk) disable iff (!aresetn)
      pwm && s.oe[4] && s.dbl[4] && m[3] && !m[4] |=> pwm_out[4])
      else $error("double edge output missed its rising match");

   a_dbl_fall:
   assert property (@(posedge aclk) disable iff (!aresetn)
      m[6] |=> !pwm_out[6])
      else $error("output stayed high after its falling match");

   a_release:
   assert property (@(posedge aclk) disable iff (!aresetn)
      pwm && m[0] && s.ld[1] |=> s.mr[1] == $past(s.sh[1]))
      else $error("released match value not applied at cycle start");

   a_std_timer:
   assert property (@(posedge aclk) disable iff (!aresetn)
      !pwm |=> pwm_out == 6'h00)
      else $error("outputs driven outside pwm mode");

   a_flag_set:
   assert property (@(posedge aclk) disable iff (!aresetn)
      m[1] && s.mcr[`MPT_M_W + `MPT_M_INT] |=> s.flag[1] ##1
      (s.flag[1] || $past(rif.wr)))
      else $error("match flag not set or not held");

   a_sync_follow:
   assert property (@(posedge aclk) disable iff (!aresetn)
      s.ctrl[`MPT_C_SLV] && !sync_in && !s.ctrl[`MPT_C_CRST] && !rif.wr
      |=> $stable(s.tc) && $stable(s.pc))
      else $error("secondary counted without primary enable");

   a_match_cont:
   assert property (@(posedge aclk) disable iff (!aresetn)
      m[1] && !do_rst && !do_stop && !rif.wr
      |=> s.tc == $past(s.tc) + 32'h1)
      else $error("continue on match did not keep counting");

   a_flag_clear:
   assert property (@(posedge aclk) disable iff (!aresetn)
      rif.wr && rif.waddr == `MPT_A_STAT && rif.wstrb[0] && rif.wdata[1]
      && !int_hit[1] |=> !s.flag[1])
      else $error("write one did not clear the match flag");

   a_irq_mask:
   assert property (@(posedge aclk) disable iff (!aresetn)
      (s.flag & s.mask) == 7'h00 |=> !irq)
      else $error("interrupt raised with no unmasked flag");

   a_ld_clear:
   assert property (@(posedge aclk) disable iff (!aresetn)
      pwm && m[0] && s.ld[1] && !rif.wr |=> !s.ld[1])
      else $error("release bit not cleared once applied");
endmodule
